// File: verilog/cksw_top.v
/*
  Carkit switch and event register bank on an AHB-Lite slave port.
  Holds switch control, event enable, status, event latch and a
  vendor conversion register; routes UART data and audio switches.
  Assumes synchronous pin inputs and a single-master AHB-Lite bus.
*/
// The AHB-Lite interface to the registers was left to the implementer.
// Contract
// RL1: link sets tx and rx routing before selecting carkit mode.
// RL2: data line one held high while rx routing is off.
// RL3: control register read at three addresses; write, set, clear.
// RL4: control bit 1 grounds the ID pin while set.
// RL5: control bit 2 routes data line zero onto DM.
// RL6: control bit 3 routes DP onto data line one.
// RL7: control bit 4 closes the DM to left speaker switch.
// RL8: DP to right speaker closed while bit 5 or bit 6 set.
// RL9: bit 7 tristates data line two in carkit mode, else drives zero.
// RL10: in UART use, closed audio switches also carry UART data.
// RL11: link avoids UART routing while audio switches are closed.
// RL12: single-ended receivers disabled while any audio switch set.
// RL13: enable register at three addresses; write, set, clear; resets zero.
// RL14: enable bits 0 and 1 flag ID float rise and fall.
// RL15: enable bit 2 flags every charger comparator change.
// RL16: unimplemented DP enable bits and DP status bit read zero.
// RL17: enable bit 5, ORed with vendor enable, flags conversion done.
// RL18: status bit 0 reports ID pin floating.
// RL19: status bit 1 mirrors charger comparator.
// RL20: status bit 6 sets when fixed-length conversion finishes.
// RL21: done clears only on vendor register read, not status read.
// RL22: enabled events captured in read-clear latch register.
// RL23: set ORs ones in, clear drops ones, read-only bits ignore.
`timescale 1ns/10ps
`include "cksw_defs.vh"
module cksw_top #(
  parameter CONV_CYCLES = `CKSW_RID_CONV_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // mode and analog status inputs
  input wire accessoryModeSelect,
  input wire identFloatIn,
  input wire chargerDetectIn,
  input wire chargerCurrentSinkEn,
  input wire identPinPullupEn,
  input wire [2:0] resistorIdentIn,
  // uart data paths
  input wire data0In,
  input wire dpLineIn,
  output wire dmTxOut,
  output wire dmTxOe,
  output wire data1Out,
  output wire data1Oe,
  output wire data2Out,
  output wire data2Oe,
  // switch controls
  output wire identPinGroundDrive,
  output wire leftSpeakerSwitch,
  output wire rightSpeakerSwitch,
  output wire uartOnLeftAudio,
  output wire uartOnRightAudio,
  output wire seRxDisable,
  // events
  output wire altIntPulse,
  output wire identFloatValid
);

  // ----------------------------------------------------------------
  // decode helper: {clear, set, write} strobes for a register triple
  // ----------------------------------------------------------------
  function [2:0] scDecode;
    input [7:0] idx;
    input [7:0] base;
    input en;
    begin
      scDecode[0] = en && (idx == base);
      scDecode[1] = en && (idx == base + 8'h01);
      scDecode[2] = en && (idx == base + 8'h02);
    end
  endfunction

  // ----------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------
  reg wrPend_ff;
  reg rdPend_ff;
  reg rdDone_ff;
  reg map_ff;
  reg [7:0] idx_ff;
  reg [31:0] hrdata_ff;
  reg [7:0] rdValue;
  wire addrTake;
  wire mapped;
  wire wrStrobe;
  wire rdStrobe;
  wire [7:0] wdata8;
  wire [2:0] ctrlSc;
  wire [2:0] ieSc;

  assign addrTake = hsel && htrans[1] && hready;
  assign mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0)
    && (hsize == 3'h2);
  // one wait state on reads so side effects land before data
  assign hreadyout = !(rdPend_ff && !rdDone_ff);
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign wdata8 = hwdata[7:0];
  assign wrStrobe = wrPend_ff && map_ff;
  assign rdStrobe = rdPend_ff && !rdDone_ff && map_ff;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      rdDone_ff <= 1'b0;
      map_ff <= 1'b0;
      idx_ff <= 8'h00;
    end
    else if (addrTake)
    begin
      wrPend_ff <= hwrite;
      rdPend_ff <= !hwrite;
      rdDone_ff <= 1'b0;
      map_ff <= mapped;
      idx_ff <= haddr[9:2];
    end
    else if (hreadyout)
    begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      rdDone_ff <= 1'b0;
    end
    else
      rdDone_ff <= 1'b1;
  end

  // read data taken in the wait cycle of each read
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_ff <= 32'h00000000;
    else if (rdPend_ff && !rdDone_ff)
      hrdata_ff <= {24'h000000, map_ff ? rdValue : 8'h00};
  end

  // ----------------------------------------------------------------
  // switch control and event enable registers
  // ----------------------------------------------------------------
  wire [7:0] ctrlQ;
  wire [7:0] ieQ;

  assign ctrlSc = scDecode(idx_ff, `CKSW_CTRL_WR_IDX, wrStrobe); // see RL3
  assign ieSc = scDecode(idx_ff, `CKSW_IE_WR_IDX, wrStrobe); // see RL13

  cksw_sc_reg #(
    .WIDTH(8),
    .MASK(`CKSW_CTRL_MASK),
    .RESET(`CKSW_CTRL_RESET)
  ) u_ctrl (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(ctrlSc[0]),
    .setEn(ctrlSc[1]),
    .clrEn(ctrlSc[2]),
    .wdata(wdata8),
    .q(ctrlQ)
  );

  cksw_sc_reg #(
    .WIDTH(8),
    .MASK(`CKSW_IE_MASK),
    .RESET(`CKSW_IE_RESET)
  ) u_ie (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(ieSc[0]),
    .setEn(ieSc[1]),
    .clrEn(ieSc[2]),
    .wdata(wdata8),
    .q(ieQ)
  );

  // ----------------------------------------------------------------
  // vendor conversion register
  // ----------------------------------------------------------------
  reg vendIe_ff;
  wire vcWrite;
  wire vcRead;
  wire convStart;
  wire convBusy;
  wire convDone;
  wire [2:0] convResult;

  assign vcWrite = wrStrobe && (idx_ff == `CKSW_VCONV_IDX);
  assign vcRead = rdStrobe && (idx_ff == `CKSW_VCONV_IDX);
  assign convStart = vcWrite && wdata8[`CKSW_VC_START_BIT];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      vendIe_ff <= 1'b0;
    else if (vcWrite)
      vendIe_ff <= wdata8[`CKSW_VC_IE_BIT];
  end

  cksw_rid_conv #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_rid (
    .clk(clk),
    .rst_n(rst_n),
    .start(convStart),
    .clearDone(vcRead), // see RL21
    .resultIn(resistorIdentIn),
    .busy(convBusy),
    .done(convDone),
    .result(convResult)
  );

  // ----------------------------------------------------------------
  // status and event detection
  // ----------------------------------------------------------------
  reg floatPrev_ff;
  reg chgPrev_ff;
  reg donePrev_ff;
  reg [7:0] latch_ff;
  reg altInt_ff;
  reg [7:0] events;
  wire chgDet;
  wire ridIeEff;
  wire latchRead;
  wire [7:0] statusVal;

  assign chgDet = chargerDetectIn && chargerCurrentSinkEn; // see RL19
  assign ridIeEff = ieQ[`CKSW_IE_RID_BIT] || vendIe_ff; // see RL17
  assign latchRead = rdStrobe && (idx_ff == `CKSW_LATCH_IDX);
  assign identFloatValid = identPinPullupEn; // see RL18

  // dp flag bit 2 and bit 7 stay zero
  assign statusVal = {1'b0, convDone, convResult, 1'b0, chgDet,
    identFloatIn}; // see RL16

  // level inputs compared with last cycle's copy
  always @*
  begin
    events = 8'h00;
    events[`CKSW_LT_FLOAT_BIT] =
      (identFloatIn && !floatPrev_ff && ieQ[`CKSW_IE_FRISE_BIT]) ||
      (!identFloatIn && floatPrev_ff && ieQ[`CKSW_IE_FFALL_BIT]); // see RL14
    events[`CKSW_LT_CHG_BIT] =
      (chgDet != chgPrev_ff) && ieQ[`CKSW_IE_CHG_BIT]; // see RL15
    events[`CKSW_LT_RID_BIT] =
      convDone && !donePrev_ff && ridIeEff; // see RL17
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      floatPrev_ff <= 1'b0;
      chgPrev_ff <= 1'b0;
      donePrev_ff <= 1'b0;
      latch_ff <= 8'h00;
      altInt_ff <= 1'b0;
    end
    else
    begin
      floatPrev_ff <= identFloatIn;
      chgPrev_ff <= chgDet;
      donePrev_ff <= convDone;
      // new event wins over the clearing read
      latch_ff <= (latchRead ? 8'h00 : latch_ff) | events; // see RL22
      altInt_ff <= |events;
    end
  end

  assign altIntPulse = altInt_ff;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @*
  begin
    case (idx_ff)
      `CKSW_CTRL_WR_IDX, `CKSW_CTRL_SET_IDX, `CKSW_CTRL_CLR_IDX:
        rdValue = ctrlQ & `CKSW_CTRL_MASK; // see RL3
      `CKSW_IE_WR_IDX, `CKSW_IE_SET_IDX, `CKSW_IE_CLR_IDX:
        rdValue = ieQ & `CKSW_IE_MASK; // see RL16
      `CKSW_STAT_IDX:
        rdValue = statusVal;
      `CKSW_LATCH_IDX:
        rdValue = latch_ff;
      `CKSW_VCONV_IDX:
        rdValue = {1'b0, convBusy, vendIe_ff, 1'b0, convDone, convResult};
      default:
        rdValue = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // switches and uart routing
  // ----------------------------------------------------------------
  wire txRoute;
  wire rxRoute;
  wire leftSw;
  wire rightSw;

  // switch outputs are pure decodes of control flops and the mode input
  assign txRoute = ctrlQ[`CKSW_CTRL_TXD_BIT];
  assign rxRoute = ctrlQ[`CKSW_CTRL_RXD_BIT];
  assign leftSw = ctrlQ[`CKSW_CTRL_SPKL_BIT];
  assign rightSw = ctrlQ[`CKSW_CTRL_SPKR_BIT]
    || ctrlQ[`CKSW_CTRL_MIC_BIT]; // see RL8

  assign identPinGroundDrive = ctrlQ[`CKSW_CTRL_GND_BIT]; // see RL4
  assign dmTxOut = data0In;
  assign dmTxOe = accessoryModeSelect && txRoute; // see RL5
  assign data1Out = rxRoute ? dpLineIn : 1'b1; // see RL2
  assign data1Oe = accessoryModeSelect; // see RL6
  assign data2Out = 1'b0;
  assign data2Oe = !(accessoryModeSelect
    && ctrlQ[`CKSW_CTRL_D2TRI_BIT]); // see RL9
  assign leftSpeakerSwitch = leftSw; // see RL7
  assign rightSpeakerSwitch = rightSw; // see RL8
  assign uartOnLeftAudio = accessoryModeSelect && txRoute
    && leftSw; // see RL10
  assign uartOnRightAudio = accessoryModeSelect && rxRoute
    && rightSw; // see RL10
  assign seRxDisable = leftSw || rightSw; // see RL12

endmodule

// File: include/cksw_defs.vh
/*
  Constants for the carkit switch and event register bank: register
  indices, field positions, masks, reset values and timing counts.
  Assumes inclusion by bare name from cksw_top and cksw_rid_conv; cksw_sc_reg does not include it.
*/
`ifndef CKSW_DEFS_VH
`define CKSW_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CKSW_CTRL_WR_IDX 8'h19
`define CKSW_CTRL_SET_IDX 8'h1A
`define CKSW_CTRL_CLR_IDX 8'h1B
`define CKSW_IE_WR_IDX 8'h1D
`define CKSW_IE_SET_IDX 8'h1E
`define CKSW_IE_CLR_IDX 8'h1F
`define CKSW_STAT_IDX 8'h20
`define CKSW_LATCH_IDX 8'h21
`define CKSW_VCONV_IDX 8'h36

// ----------------------------------------------------------------
// switch control fields
// ----------------------------------------------------------------
`define CKSW_CTRL_GND_BIT 1
`define CKSW_CTRL_TXD_BIT 2
`define CKSW_CTRL_RXD_BIT 3
`define CKSW_CTRL_SPKL_BIT 4
`define CKSW_CTRL_SPKR_BIT 5
`define CKSW_CTRL_MIC_BIT 6
`define CKSW_CTRL_D2TRI_BIT 7
`define CKSW_CTRL_MASK 8'hFE
`define CKSW_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// event enable fields
// ----------------------------------------------------------------
`define CKSW_IE_FRISE_BIT 0
`define CKSW_IE_FFALL_BIT 1
`define CKSW_IE_CHG_BIT 2
`define CKSW_IE_RID_BIT 5
`define CKSW_IE_MASK 8'h27
`define CKSW_IE_RESET 8'h00

// ----------------------------------------------------------------
// status, latch and vendor conversion fields
// ----------------------------------------------------------------
`define CKSW_ST_FLOAT_BIT 0
`define CKSW_ST_CHG_BIT 1
`define CKSW_ST_RID_LSB 3
`define CKSW_ST_DONE_BIT 6
`define CKSW_LT_FLOAT_BIT 0
`define CKSW_LT_CHG_BIT 1
`define CKSW_LT_RID_BIT 3
`define CKSW_VC_DONE_BIT 3
`define CKSW_VC_IE_BIT 5
`define CKSW_VC_START_BIT 6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CKSW_CLK_KHZ 10000
`define CKSW_RID_CONV_US 282
`define CKSW_RID_CONV_CYC (`CKSW_RID_CONV_US * `CKSW_CLK_KHZ / 1000)

`endif

// File: verilog/cksw_sc_reg.v
/*
  Byte register with direct write, bit-set and bit-clear strobes.
  Assumes at most one strobe per cycle from the bus decode.
*/
`timescale 1ns/10ps
module cksw_sc_reg #(
  parameter WIDTH = 8,
  parameter [7:0] MASK = 8'hFF,
  parameter [7:0] RESET = 8'h00
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // strobes and data
  input wire wrEn,
  input wire setEn,
  input wire clrEn,
  input wire [WIDTH-1:0] wdata,
  // register value
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] val_ff;
  reg [WIDTH-1:0] nxt_val;

  // ----------------------------------------------------------------
  // write, set, clear
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_val = val_ff;
    if (wrEn)
      nxt_val = wdata;
    else if (setEn)
      nxt_val = val_ff | wdata; // see RL23
    else if (clrEn)
      nxt_val = val_ff & ~wdata; // see RL23
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      val_ff <= RESET[WIDTH-1:0];
    else
      val_ff <= nxt_val & MASK[WIDTH-1:0]; // see RL23
  end

  assign q = val_ff;

endmodule

// File: verilog/cksw_rid_conv.v
/*
  Resistor-ID conversion timer: a start pulse runs a fixed interval,
  then the result input is captured and the done flag is set.
  Assumes the analog result is stable when the interval ends.
*/
`timescale 1ns/10ps
`include "cksw_defs.vh"
module cksw_rid_conv #(
  parameter CONV_CYCLES = `CKSW_RID_CONV_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire start,
  input wire clearDone,
  input wire [2:0] resultIn,
  // state
  output wire busy,
  output wire done,
  output wire [2:0] result
);

  reg [11:0] count_ff;
  reg busy_ff;
  reg done_ff;
  reg [2:0] result_ff;
  wire finish;

  assign finish = busy_ff && (count_ff == 12'h001);

  // ----------------------------------------------------------------
  // interval counter
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_ff <= 12'h000;
      busy_ff <= 1'b0;
      result_ff <= 3'h0;
    end
    else if (start && !busy_ff)
    begin
      count_ff <= CONV_CYCLES[11:0]; // see RL20
      busy_ff <= 1'b1;
    end
    else if (finish)
    begin
      busy_ff <= 1'b0;
      count_ff <= 12'h000;
      result_ff <= resultIn;
    end
    else if (busy_ff)
      count_ff <= count_ff - 12'h001;
  end

  // ----------------------------------------------------------------
  // done flag: finishing wins over a clearing read
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      done_ff <= 1'b0;
    else if (finish)
      done_ff <= 1'b1; // see RL20
    else if (clearDone)
      done_ff <= 1'b0; // see RL21
  end

  assign busy = busy_ff;
  assign done = done_ff;
  assign result = result_ff;

endmodule

// File: test/cksw_link_model.sv
/*
  Link-side model: carkit mode select and UART/DP line activity.
  Assumes the bench raises routed once tx/rx routing is programmed.
*/
`timescale 1ns/10ps
module cksw_link_model (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // requests from the bench
  input wire goMode,
  input wire routed,
  // pin side of the block
  output logic accessoryModeSelect,
  output logic data0In,
  output logic dpLineIn
);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      accessoryModeSelect <= 1'b0;
      data0In <= 1'b0;
      dpLineIn <= 1'b1;
    end
    else
    begin
      // mode only after routing is set
      accessoryModeSelect <= goMode & (routed | accessoryModeSelect);
      // lines change every cycle
      data0In <= ~data0In;
      dpLineIn <= data0In ^ accessoryModeSelect;
    end
  end
endmodule

// File: test/cksw_top_asserts.sv
/*
  Port-level checks of the carkit switch and event register bank.
  Assumes binding into cksw_top, single clock, async low reset.
*/
`timescale 1ns/10ps
module cksw_top_asserts (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  // pins
  input wire accessoryModeSelect,
  input wire identPinPullupEn,
  input wire data0In,
  input wire dpLineIn,
  input wire dmTxOut,
  input wire dmTxOe,
  input wire data1Out,
  input wire data2Out,
  input wire data2Oe,
  input wire leftSpeakerSwitch,
  input wire rightSpeakerSwitch,
  input wire uartOnLeftAudio,
  input wire uartOnRightAudio,
  input wire seRxDisable,
  input wire identFloatValid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_left_rx_off: assert property (
    leftSpeakerSwitch |-> seRxDisable)
    else $error("left switch without receiver disable");
  a_rx_off_cause: assert property (
    seRxDisable |-> leftSpeakerSwitch || rightSpeakerSwitch)
    else $error("receiver disable without audio switch");
  a_tx_route: assert property (
    dmTxOe |-> accessoryModeSelect && dmTxOut == data0In)
    else $error("tx route wrong");
  a_data1_hold: assert property (data1Out != dpLineIn |-> data1Out)
    else $error("data line one not high");
  a_data2_drive: assert property (
    !accessoryModeSelect |-> data2Oe && !data2Out)
    else $error("data line two not driven low");
  a_uart_left: assert property (
    uartOnLeftAudio |-> leftSpeakerSwitch && dmTxOe)
    else $error("uart on left without switch");
  a_uart_right: assert property (
    uartOnRightAudio |-> rightSpeakerSwitch && accessoryModeSelect)
    else $error("uart on right without switch");
  a_pullup_valid: assert property (
    identFloatValid == identPinPullupEn)
    else $error("float valid mismatch");
  a_read_wait: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule
bind cksw_top cksw_top_asserts chk (.clk(clk), .rst_n(rst_n), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .accessoryModeSelect(accessoryModeSelect),
  .identPinPullupEn(identPinPullupEn), .data0In(data0In),
  .dpLineIn(dpLineIn), .dmTxOut(dmTxOut), .dmTxOe(dmTxOe),
  .data1Out(data1Out), .data2Out(data2Out), .data2Oe(data2Oe),
  .leftSpeakerSwitch(leftSpeakerSwitch),
  .rightSpeakerSwitch(rightSpeakerSwitch),
  .uartOnLeftAudio(uartOnLeftAudio), .uartOnRightAudio(uartOnRightAudio),
  .seRxDisable(seRxDisable), .identFloatValid(identFloatValid));

// File: test/carkit_switch_and_event_regs_bench.sv
/*
  Self-checking bench: AHB-Lite register traffic, pins and events.
  Assumes cksw_top with a short conversion count and the link model.
*/
`timescale 1ns/10ps
module carkit_switch_and_event_regs_bench;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, goMode = 0, routed = 0;
  logic flt = 0, chg = 0, sink = 0, pull = 0, pend = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, rid = 3'h0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [7:0] expQ[$];
  logic [7:0] rstIdx[9] = '{8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1E, 8'h1F,
    8'h20, 8'h21, 8'h30};
  int errors = 0, checks_done = 0, pulses = 0, expPul = 0, cyc = 0, i;
  wire [31:0] hrdata;
  wire hreadyout, hresp, mode, d0, dp, dmTx, dmOe, d1, d1Oe, d2, d2Oe;
  wire gnd, spkL, spkR, uL, uR, seRx, pulse, fv;
  cksw_top #(.CONV_CYCLES(8)) uut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .accessoryModeSelect(mode),
    .identFloatIn(flt), .chargerDetectIn(chg),
    .chargerCurrentSinkEn(sink), .identPinPullupEn(pull),
    .resistorIdentIn(rid), .data0In(d0), .dpLineIn(dp), .dmTxOut(dmTx),
    .dmTxOe(dmOe), .data1Out(d1), .data1Oe(d1Oe), .data2Out(d2),
    .data2Oe(d2Oe), .identPinGroundDrive(gnd), .leftSpeakerSwitch(spkL),
    .rightSpeakerSwitch(spkR), .uartOnLeftAudio(uL),
    .uartOnRightAudio(uR), .seRxDisable(seRx), .altIntPulse(pulse),
    .identFloatValid(fv));
  cksw_link_model link (.clk(clk), .rst_n(rst_n), .goMode(goMode),
    .routed(routed), .accessoryModeSelect(mode), .data0In(d0),
    .dpLineIn(dp));
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task bus(input [7:0] idx, input w, input [7:0] d, input [7:0] e);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    if (!w)
      expQ.push_back(e);
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
  endtask
  task wr(input [7:0] idx, input [7:0] d);
    bus(idx, 1'b1, d, 8'h00);
  endtask
  task rd(input [7:0] idx, input [7:0] e);
    bus(idx, 1'b0, 8'h00, e);
  endtask
  task pins(input [7:0] c);
    logic m;
    logic [10:0] e;
    @(negedge clk);
    m = mode;
    e = {c[1], c[4], c[5] | c[6], |c[6:4], m & c[2], c[3] ? dp : 1'b1,
      !(m & c[7]), m & c[2] & c[4], m & c[3] & (c[5] | c[6]), m, 1'b0};
    chk("pins", e, {gnd, spkL, spkR, seRx, dmOe, d1, d2Oe, uL, uR, d1Oe,
      hresp});
  endtask
  task ctl(input [7:0] c);
    wr(8'h19, c);
    rd(8'h1A, c & 8'hFE);
    rd(8'h1B, c & 8'hFE);
    pins(c & 8'hFE);
  endtask
  // ----------------------------------------------------------------
  // clock, monitor, timeout
  // ----------------------------------------------------------------
  initial forever #50 clk = ~clk;
  always @(posedge clk)
  begin
    if (pend && hreadyout)
      chk("hrdata", expQ.pop_front(), hrdata);
    pend <= (pend && !hreadyout)
      || (hsel && htrans[1] && hreadyout && !hwrite);
    pulses <= pulses + pulse;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(2855));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i++) rd(rstIdx[i], 8'h00);
    pins(8'h00);
    for (i = 0; i < 8; i++) ctl(8'h01 << i);
    ctl(8'h60);
    ctl($urandom);
    wr(8'h19, 8'hFF);
    wr(8'h1B, 8'h0C);
    rd(8'h19, 8'hF2);
    wr(8'h1A, 8'h09);
    rd(8'h1B, 8'hFA);
    wr(8'h19, 8'h0C);
    routed <= 1'b1;
    goMode <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 8; i++) ctl(8'h8C | (8'h10 << i % 3));
    ctl(8'h70);
    ctl($urandom);
    wr(8'h1D, 8'hFF);
    rd(8'h1D, 8'h27);
    wr(8'h1F, 8'h07);
    rd(8'h1E, 8'h20);
    wr(8'h1E, 8'h03);
    rd(8'h1F, 8'h23);
    wr(8'h1D, 8'h00);
    flt <= 1'b1;
    pull <= 1'b1;
    rd(8'h21, 8'h00);
    rd(8'h20, 8'h01);
    wr(8'h1D, 8'h07);
    flt <= 1'b0;
    rd(8'h21, 8'h01);
    rd(8'h21, 8'h00);
    flt <= 1'b1;
    rd(8'h21, 8'h01);
    sink <= 1'b1;
    chg <= 1'b1;
    rd(8'h20, 8'h03);
    chg <= 1'b0;
    rd(8'h21, 8'h02);
    expPul = 4;
    chk("pulses", expPul, pulses);
    chg <= 1'b1;
    wr(8'h1D, 8'h20);
    rid <= 3'h5;
    wr(8'h36, 8'h40);
    repeat (12) @(posedge clk);
    rd(8'h20, 8'h6B);
    rd(8'h20, 8'h6B);
    rd(8'h21, 8'h0A);
    rd(8'h36, 8'h0D);
    rd(8'h20, 8'h2B);
    wr(8'h1D, 8'h00);
    rid <= 3'h2;
    wr(8'h36, 8'h60);
    repeat (12) @(posedge clk);
    rd(8'h36, 8'h2A);
    expPul = 7;
    chk("pulses", expPul, pulses);
    summarize();
  end
endmodule
